// *** phy_mgmt_pkg.sv ***
// Purpose: Constants for the PHY vendor management register bank
// Assumes: Registers are reached as aligned 32-bit words over APB
// Notes:   Register numbers 16..22 are word indices; byte address = 4*index
package phy_mgmt_pkg;
    // ------------------------------------------------------------------
    // Register indices and address width
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS_CTRL  = 8'h10;
    localparam logic [7:0] IDX_TEST_CTRL    = 8'h11;
    localparam logic [7:0] IDX_ADDR_RB      = 8'h12;
    localparam logic [7:0] IDX_FALSE_CARR   = 8'h13;
    localparam logic [7:0] IDX_DISC_CNT     = 8'h14;
    localparam logic [7:0] IDX_ERR_FRAME    = 8'h15;
    localparam logic [7:0] IDX_SYM_ERR      = 8'h16;
    localparam int         ADDR_W           = 12;

    // ------------------------------------------------------------------
    // Field positions of the status/control register
    // ------------------------------------------------------------------
    localparam int SC_DISC_EN   = 13;
    localparam int SC_TXFC_EN   = 12;
    localparam int SC_RX_SYNC   = 11;
    localparam int SC_PD_100    = 10;
    localparam int SC_PD_10     = 9;
    localparam int SC_POL_REV   = 8;
    localparam int SC_SPEED     = 1;
    localparam int SC_DUPLEX    = 0;

    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [15:0] TEST_CTRL_RST  = 16'h0000;
    localparam logic [15:0] TEST_CTRL_MASK = 16'hfbff; // Bit 10 reserved
    localparam logic [4:0]  MGMT_ADDR      = 5'h01;
    localparam logic [2:0]  SYM_RUN_LEN    = 3'h6;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam logic [15:0] CNT_ONE        = 16'h0001;
    localparam logic [15:0] CNT_ZERO       = 16'h0000;
endpackage : phy_mgmt_pkg

// *** phy_vendor_mgmt_regs.sv ***
// Purpose: Vendor management register bank of a 10/100 PHY over APB
// Assumes: Status and event inputs are synchronous to pclk
// Notes:   Zero-wait APB slave; unmapped reads return zero, pslverr low
`timescale 1ns/100ps
`default_nettype none
module phy_vendor_mgmt_regs
    import phy_mgmt_pkg::*;
(
    input  wire logic              pclk,           // APB clock, 25 MHz
    input  wire logic              presetn,        // Async reset, low
    input  wire logic              psel,           // APB select
    input  wire logic              penable,        // APB access phase
    input  wire logic              pwrite,         // APB write
    input  wire logic [ADDR_W-1:0] paddr,          // APB byte address
    input  wire logic [31:0]       pwdata,         // APB write data
    input  wire logic [3:0]        pstrb,          // APB byte strobes
    output logic      [31:0]       prdata,         // APB read data
    output logic                   pready,         // APB ready
    output logic                   pslverr,        // APB error, never set
    input  wire logic              rx_in_sync,     // 100M deserializer sync
    input  wire logic              pd_100,         // 100M section down
    input  wire logic              pd_10,          // 10M section down
    input  wire logic              pol_reversed,   // 10M polarity reversed
    input  wire logic              speed_100,      // Negotiated 100M
    input  wire logic              full_duplex,    // Negotiated full duplex
    input  wire logic              false_carrier,  // False carrier pulse
    input  wire logic              disconnect_ev,  // Disconnect pulse
    input  wire logic              rx_frame_end,   // End of frame pulse
    input  wire logic              rx_err,         // Receive error pulse
    input  wire logic              sym_err,        // Bad symbol pulse
    output logic                   disc_en,        // Disconnect enabled
    output logic                   tx_fc_en,       // Tx flow control on
    output logic      [15:0]       test_ctrl       // Test/special controls
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Saturating step used by all four counters; read clear folds in
    function automatic logic [15:0] cnt_next(input logic [15:0] cur,
                                             input logic        ev,
                                             input logic        clr);
        logic [15:0] base;
        base = clr ? CNT_ZERO : cur;
        if (ev && base != CNT_MAX) begin
            cnt_next = base + CNT_ONE;
        end else begin
            cnt_next = base;
        end
    endfunction : cnt_next

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        idx);
        hit = (a == {{(ADDR_W-10){1'b0}}, idx, 2'b00});
    endfunction : hit

    logic wr_acc;
    logic rd_setup;
    logic lo_en;
    logic hi_en;
    assign wr_acc = psel && penable && pwrite;
    // Reads clear counters in the setup cycle, at the same edge that
    // captures prdata, so no event can slip between capture and clear
    assign rd_setup = psel && !penable && !pwrite;
    assign lo_en  = pstrb[0];
    assign hi_en  = pstrb[1];

    // ------------------------------------------------------------------
    // Status/control writable bits
    // ------------------------------------------------------------------
    // Only bits 13 and 12 store; reserved bits 15:14 read back as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disc_en  <= 1'b0;
            tx_fc_en <= 1'b0;
        end else if (wr_acc && hi_en && hit(paddr, IDX_STATUS_CTRL)) begin
            disc_en  <= pwdata[SC_DISC_EN];
            tx_fc_en <= pwdata[SC_TXFC_EN];
        end
    end

    // ------------------------------------------------------------------
    // Test/special control register, drives the PHY datapath directly
    // ------------------------------------------------------------------
    // Each byte lane honours its strobe; reserved bit 10 never stores
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_ctrl <= TEST_CTRL_RST;
        end else if (wr_acc && hit(paddr, IDX_TEST_CTRL)) begin
            if (hi_en) begin
                test_ctrl[15:8] <= pwdata[15:8] & TEST_CTRL_MASK[15:8];
            end
            if (lo_en) begin
                test_ctrl[7:0] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame tracking for error frame and symbol run counting
    // ------------------------------------------------------------------
    // A frame is open from the first event to rx_frame_end
    // A bad symbol marks the frame errored as any receive error does
    logic       frame_err_seen;
    logic [2:0] sym_run;
    logic       err_frame_ev;
    logic       sym_ev;
    assign err_frame_ev = (rx_err || sym_err) && !frame_err_seen;
    assign sym_ev       = sym_err && sym_run == 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_err_seen <= 1'b0;
        end else if (rx_frame_end) begin
            frame_err_seen <= 1'b0;
        end else if (rx_err || sym_err) begin
            frame_err_seen <= 1'b1;
        end
    end

    // Counts within a run of six; a good symbol is not reported, so the
    // run restarts only after six bad symbols or at frame end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sym_run <= 3'h0;
        end else if (rx_frame_end) begin
            sym_run <= 3'h0;
        end else if (sym_err) begin
            sym_run <= (sym_run == SYM_RUN_LEN - 3'h1) ? 3'h0
                                                      : sym_run + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Clear-on-read saturating counters
    // ------------------------------------------------------------------
    logic [15:0] fc_cnt;
    logic [15:0] disc_cnt;
    logic [15:0] ef_cnt;
    logic [15:0] se_cnt;
    logic        rd_fc;
    logic        rd_disc;
    logic        rd_ef;
    logic        rd_se;
    assign rd_fc   = rd_setup && hit(paddr, IDX_FALSE_CARR);
    assign rd_disc = rd_setup && hit(paddr, IDX_DISC_CNT);
    assign rd_ef   = rd_setup && hit(paddr, IDX_ERR_FRAME);
    assign rd_se   = rd_setup && hit(paddr, IDX_SYM_ERR);

    // Read clears, an event in the same cycle survives as one count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc_cnt   <= CNT_ZERO;
            disc_cnt <= CNT_ZERO;
            ef_cnt   <= CNT_ZERO;
            se_cnt   <= CNT_ZERO;
        end else begin
            fc_cnt   <= cnt_next(fc_cnt, false_carrier, rd_fc);
            disc_cnt <= cnt_next(disc_cnt, disconnect_ev, rd_disc);
            ef_cnt   <= cnt_next(ef_cnt, err_frame_ev, rd_ef);
            se_cnt   <= cnt_next(se_cnt, sym_ev, rd_se);
        end
    end

    // ------------------------------------------------------------------
    // Read mux and APB response
    // ------------------------------------------------------------------
    logic [15:0] rd_word;
    always_comb begin
        rd_word = CNT_ZERO;
        if (hit(paddr, IDX_STATUS_CTRL)) begin
            rd_word[SC_DISC_EN] = disc_en;
            rd_word[SC_TXFC_EN] = tx_fc_en;
            rd_word[SC_RX_SYNC] = rx_in_sync;
            rd_word[SC_PD_100]  = pd_100;
            rd_word[SC_PD_10]   = pd_10;
            rd_word[SC_POL_REV] = pol_reversed;
            rd_word[SC_SPEED]   = speed_100;
            rd_word[SC_DUPLEX]  = full_duplex;
        end else if (hit(paddr, IDX_TEST_CTRL)) begin
            rd_word = test_ctrl;
        end else if (hit(paddr, IDX_ADDR_RB)) begin
            rd_word[4:0] = MGMT_ADDR;
        end else if (hit(paddr, IDX_FALSE_CARR)) begin
            rd_word = fc_cnt;
        end else if (hit(paddr, IDX_DISC_CNT)) begin
            rd_word = disc_cnt;
        end else if (hit(paddr, IDX_ERR_FRAME)) begin
            rd_word = ef_cnt;
        end else if (hit(paddr, IDX_SYM_ERR)) begin
            rd_word = se_cnt;
        end
    end

    // Data registered in setup so the access phase ends in one cycle;
    // the pre-clear value is what software sees
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, rd_word};
        end
    end

    // Ready rises for the access cycle only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // No error response: unmapped words read zero and ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_DISC_WR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hi_en && hit(paddr, IDX_STATUS_CTRL)
        |=> disc_en == $past(pwdata[SC_DISC_EN]))
        else $error("disconnect enable not written");
    AST_TXFC_WR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hi_en && hit(paddr, IDX_STATUS_CTRL)
        |=> tx_fc_en == $past(pwdata[SC_TXFC_EN]))
        else $error("flow control enable not written");
    AST_PD_READ: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit(paddr, IDX_STATUS_CTRL)
        |=> prdata[SC_PD_100] == $past(pd_100)
            && prdata[SC_PD_10] == $past(pd_10))
        else $error("power-down flags wrong");
    AST_RSVD10: assert property (@(posedge pclk) disable iff (!presetn)
        (test_ctrl & ~TEST_CTRL_MASK) == CNT_ZERO)
        else $error("reserved test bit stored");
    AST_ADDR_RB: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit(paddr, IDX_ADDR_RB)
        |=> prdata == 32'h0000_0001)
        else $error("address readback wrong");
    AST_SAT: assert property (@(posedge pclk) disable iff (!presetn)
        disc_cnt == CNT_MAX && !rd_disc |=> disc_cnt == CNT_MAX)
        else $error("disconnect counter wrapped");
    AST_CLR_EV: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fc && false_carrier |=> fc_cnt == CNT_ONE)
        else $error("event lost on clearing read");
    AST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fc && !false_carrier |=> fc_cnt == CNT_ZERO)
        else $error("false carrier not cleared");
    AST_EF_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        frame_err_seen && !rd_ef |=> ef_cnt == $past(ef_cnt))
        else $error("error frame counted twice");
    AST_SYM_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        sym_run != 3'h0 && !rd_se |=> se_cnt == $past(se_cnt))
        else $error("symbol run counted twice");
    AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle");
    AST_RDY_IDL: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pready)
        else $error("ready without a transfer");
    AST_NO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> !pslverr)
        else $error("error response raised");
    AST_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:16] == CNT_ZERO)
        else $error("upper read half not zero");

    // Control registers change only on a write that addresses them
    AST_TEST_HI: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hi_en && hit(paddr, IDX_TEST_CTRL)
        |=> test_ctrl[15:8] == ($past(pwdata[15:8]) & TEST_CTRL_MASK[15:8]))
        else $error("test control high lane not written");
    AST_TEST_LO: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && lo_en && hit(paddr, IDX_TEST_CTRL)
        |=> test_ctrl[7:0] == $past(pwdata[7:0]))
        else $error("test control low lane not written");
    AST_TEST_ST: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && hit(paddr, IDX_TEST_CTRL)) |=> $stable(test_ctrl))
        else $error("test control changed without a write");
    AST_CTRL_ST: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_acc && hi_en && hit(paddr, IDX_STATUS_CTRL))
        |=> $stable(disc_en) && $stable(tx_fc_en))
        else $error("status controls changed without a write");

    // Status reads return the live inputs seen at the setup edge
    AST_SYNC_RD: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit(paddr, IDX_STATUS_CTRL)
        |=> prdata[SC_RX_SYNC] == $past(rx_in_sync))
        else $error("sync flag wrong");
    AST_POL_RD: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit(paddr, IDX_STATUS_CTRL)
        |=> prdata[SC_POL_REV] == $past(pol_reversed))
        else $error("polarity flag wrong");
    AST_LINK_RD: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit(paddr, IDX_STATUS_CTRL)
        |=> prdata[SC_SPEED] == $past(speed_100)
            && prdata[SC_DUPLEX] == $past(full_duplex))
        else $error("speed or duplex flag wrong");

    // Counters step by one per event until full; a read returns the
    // value held before its clear
    AST_FC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_fc && false_carrier && fc_cnt != CNT_MAX
        |=> fc_cnt == $past(fc_cnt) + CNT_ONE)
        else $error("false carrier not counted");
    AST_CNT_RD: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fc |=> prdata == {16'h0000, $past(fc_cnt)})
        else $error("read did not return the pre-clear count");
    AST_DISC_CL: assert property (@(posedge pclk) disable iff (!presetn)
        rd_disc && !disconnect_ev |=> disc_cnt == CNT_ZERO)
        else $error("disconnect counter not cleared");
    AST_DISC_ST: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_disc && disconnect_ev && disc_cnt != CNT_MAX
        |=> disc_cnt == $past(disc_cnt) + CNT_ONE)
        else $error("disconnect event not counted");
    AST_EF_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_ef && (rx_err || sym_err) && !frame_err_seen
            && ef_cnt != CNT_MAX
        |=> ef_cnt == $past(ef_cnt) + CNT_ONE)
        else $error("first error of a frame not counted");
    AST_SE_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_se && sym_err && sym_run == 3'h0
            && se_cnt != CNT_MAX
        |=> se_cnt == $past(se_cnt) + CNT_ONE)
        else $error("first symbol of a run not counted");

    // Frame tracking opens on an error and closes at frame end
    AST_ERR_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_err || sym_err) && !rx_frame_end |=> frame_err_seen)
        else $error("errored frame not marked");
    AST_FRM_END: assert property (@(posedge pclk) disable iff (!presetn)
        rx_frame_end |=> !frame_err_seen && sym_run == 3'h0)
        else $error("frame end did not reset tracking");

endmodule : phy_vendor_mgmt_regs
`default_nettype wire

// *** mgmt_apb_master.sv ***
// Purpose: Model of the MAC-side management controller as an APB master
// Assumes: Slave answers with pready; data are 32-bit aligned words
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module mgmt_apb_master
    import phy_mgmt_pkg::*;
(
    input  wire logic              pclk,    // APB clock
    output logic                   psel,    // Select
    output logic                   penable, // Access phase
    output logic                   pwrite,  // Direction
    output logic      [ADDR_W-1:0] paddr,   // Byte address
    output logic      [31:0]       pwdata,  // Write data
    output logic      [3:0]        pstrb,   // Byte strobes
    input  wire logic [31:0]       prdata,  // Read data
    input  wire logic              pready,  // Ready
    input  wire logic              pslverr  // Error, fails the transfer
);
    // ------------------------------------------------------------------
    // Idle levels at time zero
    // ------------------------------------------------------------------
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
    end

    // One whole transfer; only the bench's watchdog ends a long wait
    task xfer(input logic wr, input logic [ADDR_W-1:0] a,
              input logic [31:0] d, input logic [3:0] s,
              output logic [31:0] rd, output logic ok);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        ok = (pslverr === 1'b0); // An error response fails the transfer
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a; // Stale bus must not look valid
        pwdata  <= ~d;
    endtask : xfer
endmodule : mgmt_apb_master
`default_nettype wire

// *** phy_vendor_mgmt_regs_tb_top.sv ***
// Purpose: Self-checking bench for the PHY management register bank
// Assumes: Zero-wait slave; events are one-cycle pulses on pclk
// Notes:   Saturation run holds an event high for 65540 cycles
`timescale 1ns/100ps
`default_nettype none
module phy_vendor_mgmt_regs_tb_top;
    import phy_mgmt_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, v;
    logic [3:0]        pstrb;
    logic [5:0]        st = 6'h0;  // sync,pd100,pd10,pol,speed,duplex
    logic [4:0]        ev = 5'h0;  // fc,disc,end,err,sym
    logic              disc_en, tx_fc_en;
    logic [15:0]       test_ctrl;
    int                num_errors = 0;
    int                n_tests = 0;

    // ------------------------------------------------------------------
    // Clock, partner and device
    // ------------------------------------------------------------------
    always #20 pclk = ~pclk;
    mgmt_apb_master u_mgr (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    phy_vendor_mgmt_regs u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in_sync(st[5]), .pd_100(st[4]),
        .pd_10(st[3]), .pol_reversed(st[2]), .speed_100(st[1]),
        .full_duplex(st[0]), .false_carrier(ev[0]),
        .disconnect_ev(ev[1]), .rx_frame_end(ev[2]), .rx_err(ev[3]),
        .sym_err(ev[4]), .disc_en(disc_en), .tx_fc_en(tx_fc_en),
        .test_ctrl(test_ctrl));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task summarize;
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task rw(input logic wr, input logic [7:0] idx, input logic [31:0] d,
            input logic [3:0] s);
        logic ok;
        u_mgr.xfer(wr, ADDR_W'({idx, 2'b00}), d, s, v, ok);
        check({31'h0, ok}, 32'h1); // Transfer ends without error
    endtask : rw
    task pulse(input int b, input int n);
        repeat (n) begin
            @(posedge pclk);
            ev[b] <= 1'b1;
            @(posedge pclk);
            ev[b] <= 1'b0;
        end
    endtask : pulse
    // Status word expected from the control bits and status inputs
    function automatic logic [31:0] sexp(input logic dc, input logic fc);
        return {18'h0, dc, fc, st[5:2], 6'h0, st[1:0]};
    endfunction : sexp

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        check({14'h0, disc_en, tx_fc_en, test_ctrl}, 32'h0);
        rw(1'b0, IDX_TEST_CTRL, 32'h0, 4'h0);
        check(v, 32'h0);
        for (int i = 19; i <= 22; i++) begin
            rw(1'b0, 8'(i), 32'h0, 4'h0);
            check(v, 32'h0);
        end
    endtask : t_reset
    task t_status;
        st <= 6'h2a;
        rw(1'b1, IDX_STATUS_CTRL, 32'hffff_ffff, 4'hf);
        rw(1'b0, IDX_STATUS_CTRL, 32'h0, 4'h0);
        check(v, sexp(1'b1, 1'b1));
        check({30'h0, disc_en, tx_fc_en}, 32'h3);
        st <= 6'h15;
        rw(1'b1, IDX_STATUS_CTRL, 32'h0, 4'h1); // No lane 1, no store
        rw(1'b0, IDX_STATUS_CTRL, 32'h0, 4'h0);
        check(v, sexp(1'b1, 1'b1));
        rw(1'b1, IDX_STATUS_CTRL, 32'h0, 4'hf);
        rw(1'b0, IDX_STATUS_CTRL, 32'h0, 4'h0);
        check(v, sexp(1'b0, 1'b0));
    endtask : t_status
    task t_test;
        logic [31:0] e;
        for (int b = 0; b < 16; b++) begin
            rw(1'b1, IDX_TEST_CTRL, 32'h1 << b, 4'hf);
            rw(1'b0, IDX_TEST_CTRL, 32'h0, 4'h0);
            e = {16'h0, 16'h1 << b} & {16'h0, TEST_CTRL_MASK};
            check(v, e);
            check({16'h0, test_ctrl}, v);
        end
        rw(1'b1, IDX_TEST_CTRL, 32'hffff, 4'h1); // Low lane only
        rw(1'b0, IDX_TEST_CTRL, 32'h0, 4'h0);
        check(v, 32'h80ff);
    endtask : t_test
    task t_fixed;
        rw(1'b1, IDX_ADDR_RB, 32'hffff, 4'hf);
        rw(1'b0, IDX_ADDR_RB, 32'h0, 4'h0);
        check(v, 32'h1);
        rw(1'b1, 8'h17, 32'hffff, 4'hf);
        rw(1'b0, 8'h17, 32'h0, 4'h0);
        check(v, 32'h0);
    endtask : t_fixed
    task t_counts;
        pulse(0, 5);
        pulse(1, 3);
        pulse(3, 3); // Three errors in one frame count once
        pulse(2, 1);
        pulse(3, 1);
        pulse(2, 1);
        pulse(4, 12); // Symbols 1 and 7 of the frame count
        pulse(2, 1);
        pulse(4, 1);
        pulse(2, 1);
        rw(1'b0, IDX_FALSE_CARR, 32'h0, 4'h0);
        check(v, 32'h5);
        rw(1'b0, IDX_DISC_CNT, 32'h0, 4'h0);
        check(v, 32'h3);
        rw(1'b0, IDX_ERR_FRAME, 32'h0, 4'h0);
        check(v, 32'h4);
        rw(1'b0, IDX_SYM_ERR, 32'h0, 4'h0);
        check(v, 32'h3);
        rw(1'b0, IDX_ERR_FRAME, 32'h0, 4'h0);
        check(v, 32'h0);
    endtask : t_counts
    task t_race;
        pulse(0, 2);
        // Event in the setup cycle first, then in the access cycle
        for (int k = 1; k <= 2; k++) begin
            fork
                rw(1'b0, IDX_FALSE_CARR, 32'h0, 4'h0);
                begin
                    repeat (k) @(posedge pclk);
                    ev[0] <= 1'b1;
                    @(posedge pclk);
                    ev[0] <= 1'b0;
                end
            join
            check(v, 32'h3 - k);
        end
        rw(1'b0, IDX_FALSE_CARR, 32'h0, 4'h0);
        check(v, 32'h1);
        rw(1'b0, IDX_FALSE_CARR, 32'h0, 4'h0);
        check(v, 32'h0);
    endtask : t_race
    task t_sat;
        @(posedge pclk);
        ev[1] <= 1'b1;
        repeat (65540) @(posedge pclk);
        ev[1] <= 1'b0;
        rw(1'b0, IDX_DISC_CNT, 32'h0, 4'h0);
        check(v, 32'hffff);
        rw(1'b0, IDX_DISC_CNT, 32'h0, 4'h0);
        check(v, 32'h0);
    endtask : t_sat

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_status();
        t_test();
        t_fixed();
        t_counts();
        t_race();
        t_sat();
        summarize();
    end
    initial begin
        #4_000_000;
        num_errors++;
        summarize();
    end
endmodule : phy_vendor_mgmt_regs_tb_top
`default_nettype wire
